// ===== core/supervisor_pkg.sv
// Operation
// - steady kick past timeout: fault low, reset
// - fault stays low until next kick change or watchdog off
// - floating kick input disables the watchdog
// - fault flag high while kick floats
// - supply-low indicator follows threshold one cycle later, no stretch
// - reset while supply low, then stretched
// - open-drain high reset inverts low reset
// - memory select gate opens only outside reset
// - select held low at most 16us
// - select pin picks internal or external timebase
// - timebase level picks fast or slow watchdog
// - backup comparator never touches reset
// - early-fail output follows its comparator only
// - kick changes under 100ns are ignored
// - fast mode: 100ms, first period 1.6s
// - watchdog frozen while supply below threshold
// - backup flag needs supply below both levels
package supervisor_pkg;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned WD_LONG_MS    = 1600;
  localparam int unsigned WD_SHORT_MS   = 100;
  localparam int unsigned RST_MS        = 200;
  localparam int unsigned CE_HOLD_US    = 16;
  localparam int unsigned KICK_MIN_NS   = 100;
  // longest times round down, least times round up
  localparam int unsigned WD_LONG_CYC   = WD_LONG_MS * (CLK_HZ / 1000);
  localparam int unsigned WD_SHORT_CYC  = WD_SHORT_MS * (CLK_HZ / 1000);
  localparam int unsigned RST_CYC       = RST_MS * (CLK_HZ / 1000);
  localparam logic [10:0] CE_HOLD_CYC   = 11'(CE_HOLD_US * (CLK_HZ / 1_000_000));
  localparam logic [3:0]  KICK_MIN_CYC  =
    4'((KICK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // external timebase periods, in timebase edges
  localparam logic [31:0] EXT_WD_NORM   = 32'h0000_0400;
  localparam logic [31:0] EXT_WD_FIRST  = 32'h0000_1000;
  localparam logic [31:0] EXT_RST       = 32'h0000_0800;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] CTRL_OFS       = 8'h00;
  localparam logic [7:0] STATUS_OFS     = 8'h04;
  localparam logic [7:0] IRQ_STATUS_OFS = 8'h08;
  localparam logic [7:0] IRQ_ENABLE_OFS = 8'h0c;
  localparam logic [7:0] IRQ_CLEAR_OFS  = 8'h10;
  localparam logic       CTRL_RESET     = 1'b1;
  localparam int unsigned EVT_W         = 4;

  // live state shown in the status register
  typedef struct packed {
    logic first_period;
    logic backup_active;
    logic reset_active;
    logic watchdog_fault_n;
    logic supply_low_n;
  } status_s;

  // sticky events, same layout in status, enable and clear
  typedef struct packed {
    logic early_fail_fall;
    logic reset_release;
    logic supply_fall;
    logic wd_timeout;
  } event_s;

  typedef enum logic [1:0] {
    ST_HOLD,
    ST_STRETCH,
    ST_RUN
  } sup_state_e;

endpackage : supervisor_pkg

// ===== core/supply_supervisor_watchdog.sv
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module supply_supervisor_watchdog #(
  parameter int unsigned WD_LONG  = supervisor_pkg::WD_LONG_CYC,
  parameter int unsigned WD_SHORT = supervisor_pkg::WD_SHORT_CYC,
  parameter int unsigned RST_LEN  = supervisor_pkg::RST_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  input  wire logic        supply_below,
  input  wire logic        supply_below_backup,
  input  wire logic        watchdog_kick_in,
  input  wire logic        watchdog_kick_float,
  input  wire logic        timebase_select,
  input  wire logic        timebase_in,
  input  wire logic        early_fail_sense,
  input  wire logic        mem_select_in_n,
  output logic             mem_select_out_n,
  output logic             watchdog_fault_n,
  output logic             supply_low_n,
  output logic             reset_n,
  output logic             reset_hi_o,
  output logic             reset_hi_oe,
  output logic             early_fail_n,
  output logic             backup_active
);
  import supervisor_pkg::*;

  function automatic logic addr_is(input logic [31:0] a, input logic [7:0] ofs);
    addr_is = (a[31:8] == 24'h000000) && (a[7:0] == ofs);
  endfunction : addr_is

  // ************************************************************
  // kick filter and timebase
  // ************************************************************
  logic       kick_level_reg;
  logic       kick_level_next;
  logic [3:0] kick_cnt_reg;
  logic [3:0] kick_cnt_next;
  logic       kick_edge;
  logic       tb_prev_reg;
  logic       tick;

  // a change must stand for the minimum width before it counts
  always_comb begin
    kick_level_next = kick_level_reg;
    kick_cnt_next   = 4'h0;
    kick_edge       = 1'b0;
    if (watchdog_kick_in != kick_level_reg) begin
      if (kick_cnt_reg == KICK_MIN_CYC - 4'h1) begin
        kick_level_next = watchdog_kick_in;
        kick_edge       = 1'b1;
      end else begin
        kick_cnt_next = kick_cnt_reg + 4'h1;
      end
    end
  end

  // internal oscillator is pclk; external mode counts rising edges
  assign tick = timebase_select | (timebase_in & ~tb_prev_reg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      kick_level_reg <= 1'b0;
      kick_cnt_reg   <= 4'h0;
      tb_prev_reg    <= 1'b0;
    end else begin
      kick_level_reg <= kick_level_next;
      kick_cnt_reg   <= kick_cnt_next;
      tb_prev_reg    <= timebase_in;
    end
  end

  // ************************************************************
  // reset stretcher and watchdog
  // ************************************************************
  sup_state_e  state_reg;
  sup_state_e  state_next;
  logic [31:0] rst_cnt_reg;
  logic [31:0] rst_cnt_next;
  logic [31:0] wd_cnt_reg;
  logic [31:0] wd_cnt_next;
  logic        fault_n_reg;
  logic        fault_n_next;
  logic        first_reg;
  logic        first_next;
  logic        reset_active_reg;
  logic        reset_active_next;
  logic        wd_timeout;
  logic        wd_run;
  logic        wd_off;
  logic [31:0] wd_limit;
  logic [31:0] rst_limit;
  logic        ctrl_wd_en_reg;

  // timeout lengths for the selected timebase
  always_comb begin
    if (timebase_select) begin
      rst_limit = RST_LEN;
      if (first_reg || timebase_in) begin
        wd_limit = WD_LONG;
      end else begin
        wd_limit = WD_SHORT;
      end
    end else begin
      rst_limit = EXT_RST;
      wd_limit  = first_reg ? EXT_WD_FIRST : EXT_WD_NORM;
    end
  end

  // battery comparator is deliberately absent from all of this
  assign wd_off = ~ctrl_wd_en_reg | watchdog_kick_float | supply_below;
  assign wd_run = (state_reg == ST_RUN) & ~wd_off;

  // state, counters and fault flag
  always_comb begin
    state_next   = state_reg;
    rst_cnt_next = rst_cnt_reg;
    wd_cnt_next  = wd_cnt_reg;
    first_next   = first_reg;
    wd_timeout   = 1'b0;
    case (state_reg)
      ST_HOLD: begin
        rst_cnt_next = 32'h0;
        state_next   = ST_STRETCH;
      end
      ST_STRETCH: begin
        if (tick) begin
          if (rst_cnt_reg >= rst_limit - 32'h1) begin
            state_next = ST_RUN;
            first_next = 1'b1;
          end else begin
            rst_cnt_next = rst_cnt_reg + 32'h1;
          end
        end
      end
      ST_RUN: begin
        rst_cnt_next = 32'h0;
      end
      default: begin
        state_next = ST_HOLD;
      end
    endcase
    if (!wd_run) begin
      wd_cnt_next = 32'h0;
    end else if (kick_edge) begin
      wd_cnt_next = 32'h0;
      first_next  = 1'b0;
    end else if (tick) begin
      if (wd_cnt_reg >= wd_limit - 32'h1) begin
        wd_timeout   = 1'b1;
        wd_cnt_next  = 32'h0;
        state_next   = ST_STRETCH;
        rst_cnt_next = 32'h0;
      end else begin
        wd_cnt_next = wd_cnt_reg + 32'h1;
      end
    end
    if (supply_below) begin
      state_next = ST_HOLD;
    end
    reset_active_next = (state_next != ST_RUN);
    if (wd_off) begin
      fault_n_next = 1'b1;
    end else if (wd_timeout) begin
      fault_n_next = 1'b0;
    end else if (kick_edge) begin
      fault_n_next = 1'b1;
    end else begin
      fault_n_next = fault_n_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg        <= ST_HOLD;
      rst_cnt_reg      <= 32'h0;
      wd_cnt_reg       <= 32'h0;
      first_reg        <= 1'b1;
      fault_n_reg      <= 1'b1;
      reset_active_reg <= 1'b1;
    end else begin
      state_reg        <= state_next;
      rst_cnt_reg      <= rst_cnt_next;
      wd_cnt_reg       <= wd_cnt_next;
      first_reg        <= first_next;
      fault_n_reg      <= fault_n_next;
      reset_active_reg <= reset_active_next;
    end
  end

  // ************************************************************
  // memory select gate and plain outputs
  // ************************************************************
  logic        gate_open_reg;
  logic        gate_open_next;
  logic [10:0] hold_cnt_reg;
  logic [10:0] hold_cnt_next;
  logic        mem_out_n_reg;
  logic        supply_low_n_reg;
  logic        early_fail_n_reg;
  logic        backup_reg;

  // gate opens only outside reset; an access in flight gets a short hold
  always_comb begin
    gate_open_next = gate_open_reg;
    hold_cnt_next  = 11'h000;
    if (!reset_active_next) begin
      gate_open_next = 1'b1;
    end else if (gate_open_reg) begin
      if (mem_select_in_n || hold_cnt_reg == CE_HOLD_CYC) begin
        gate_open_next = 1'b0;
      end else begin
        hold_cnt_next = hold_cnt_reg + 11'h001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_open_reg    <= 1'b0;
      hold_cnt_reg     <= 11'h000;
      mem_out_n_reg    <= 1'b1;
      supply_low_n_reg <= 1'b1;
      early_fail_n_reg <= 1'b1;
      backup_reg       <= 1'b0;
    end else begin
      gate_open_reg    <= gate_open_next;
      hold_cnt_reg     <= hold_cnt_next;
      mem_out_n_reg    <= ~(gate_open_next & ~mem_select_in_n);
      supply_low_n_reg <= ~supply_below;
      early_fail_n_reg <= early_fail_sense;
      backup_reg       <= supply_below & supply_below_backup;
    end
  end

  // pins come straight from flip-flops, except reset_n and reset_hi_oe, which invert reset_active_reg, and reset_hi_o, which is tied low
  assign mem_select_out_n = mem_out_n_reg;
  assign supply_low_n     = supply_low_n_reg;
  assign early_fail_n     = early_fail_n_reg;
  assign backup_active    = backup_reg;
  assign watchdog_fault_n = fault_n_reg;
  assign reset_n          = ~reset_active_reg;
  assign reset_hi_o       = 1'b0;
  assign reset_hi_oe      = ~reset_active_reg;

  // ************************************************************
  // apb registers and interrupt
  // ************************************************************
  event_s      evt;
  event_s      irq_status_reg;
  event_s      irq_status_next;
  event_s      irq_enable_reg;
  event_s      irq_enable_next;
  event_s      irq_clear;
  logic        ctrl_wd_en_next;
  logic        supply_prev_reg;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  status_s     status;
  logic        wr;
  logic        mapped;

  assign status = '{first_reg, backup_reg, reset_active_reg, fault_n_reg, supply_low_n_reg};
  assign evt    = '{early_fail_n_reg & ~early_fail_sense,
                    reset_active_reg & ~reset_active_next,
                    supply_below & ~supply_prev_reg,
                    wd_timeout};
  assign wr     = psel & penable & pwrite;
  assign mapped = addr_is(paddr, CTRL_OFS) | addr_is(paddr, STATUS_OFS)
                | addr_is(paddr, IRQ_STATUS_OFS) | addr_is(paddr, IRQ_ENABLE_OFS)
                | addr_is(paddr, IRQ_CLEAR_OFS);

  // writes, sticky events (set beats clear) and read mux
  always_comb begin
    ctrl_wd_en_next = ctrl_wd_en_reg;
    irq_enable_next = irq_enable_reg;
    irq_clear       = '0;
    prdata_next     = prdata_reg;
    if (wr && addr_is(paddr, CTRL_OFS)) begin
      ctrl_wd_en_next = pwdata[0];
    end
    if (wr && addr_is(paddr, IRQ_ENABLE_OFS)) begin
      irq_enable_next = event_s'(pwdata[EVT_W-1:0]);
    end
    if (wr && addr_is(paddr, IRQ_CLEAR_OFS)) begin
      irq_clear = event_s'(pwdata[EVT_W-1:0]);
    end
    irq_status_next = (irq_status_reg & ~irq_clear) | evt;
    if (psel && !penable) begin
      prdata_next = 32'h0;
      if (addr_is(paddr, CTRL_OFS)) begin
        prdata_next = {31'h0, ctrl_wd_en_reg};
      end else if (addr_is(paddr, STATUS_OFS)) begin
        prdata_next = {27'h0, status};
      end else if (addr_is(paddr, IRQ_STATUS_OFS)) begin
        prdata_next = {28'h0, irq_status_reg};
      end else if (addr_is(paddr, IRQ_ENABLE_OFS)) begin
        prdata_next = {28'h0, irq_enable_reg};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_wd_en_reg  <= CTRL_RESET;
      irq_enable_reg  <= '0;
      irq_status_reg  <= '0;
      supply_prev_reg <= 1'b0;
      prdata_reg      <= 32'h0;
    end else begin
      ctrl_wd_en_reg  <= ctrl_wd_en_next;
      irq_enable_reg  <= irq_enable_next;
      irq_status_reg  <= irq_status_next;
      supply_prev_reg <= supply_below;
      prdata_reg      <= prdata_next;
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign irq     = |(irq_status_reg & irq_enable_reg);

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence timeout_s;
    wd_timeout;
  endsequence
  sequence pulse_s;
    (!watchdog_fault_n && !reset_n);
  endsequence

  wd_timeout_a: assert property (timeout_s |=> pulse_s)
    else $error("timeout did not raise fault and reset");
  fault_release_a: assert property (!fault_n_reg && kick_edge && !wd_off |=> watchdog_fault_n)
    else $error("fault flag not released by kick");
  float_high_a: assert property (watchdog_kick_float |=> watchdog_fault_n ##0 wd_cnt_reg == 32'h0)
    else $error("floating kick left watchdog active");
  supply_low_a: assert property (supply_below |=> !supply_low_n && !reset_n)
    else $error("supply low not reflected");
  supply_rel_a: assert property ($fell(supply_below) |-> ##1 supply_low_n ##1 !reset_n)
    else $error("supply low release wrong");
  reset_inv_a: assert property (reset_hi_oe == reset_n && !reset_hi_o)
    else $error("high reset not inverse of low reset");
  gate_block_a: assert property (mem_select_in_n || (supply_below && !gate_open_reg) |=> mem_select_out_n)
    else $error("memory select passed while blocked");
  gate_hold_a: assert property (reset_active_next && hold_cnt_reg == CE_HOLD_CYC |=> mem_select_out_n)
    else $error("memory select held too long");
  early_fail_a: assert property (##1 early_fail_n == $past(early_fail_sense))
    else $error("early fail output wrong");
  backup_flag_a: assert property (##1 backup_active == $past(supply_below && supply_below_backup))
    else $error("backup flag wrong");
  wd_frozen_a: assert property (reset_active_reg |-> wd_cnt_reg == 32'h0)
    else $error("watchdog ran during reset");

endmodule : supply_supervisor_watchdog
`default_nettype wire

// ===== verification/cpu_ram_model.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// processor side: kick source and external timebase
// ************************************************************
module cpu_ram_model (
  input  wire logic pclk,
  input  wire logic kick_run,
  input  wire logic glitch,
  input  wire logic ext_run,
  input  wire logic slow,
  output logic      kick,
  output logic      timebase_in
);
  logic       level = 1'b0;
  logic       tick  = 1'b0;
  logic [4:0] cnt   = 5'h00;

  // kick level toggles every 20 cycles, well above the minimum hold
  always @(posedge pclk) begin
    cnt <= (kick_run && cnt != 5'h13) ? cnt + 5'h01 : 5'h00;
    if (kick_run && cnt == 5'h13) level <= ~level;
    tick <= ext_run ? ~tick : 1'b0;
  end

  // short pulses appear only when the bench commands one
  assign kick        = level ^ glitch;
  assign timebase_in = ext_run ? tick : slow;
endmodule : cpu_ram_model
`default_nettype wire

// ===== verification/supply_supervisor_watchdog_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// bench
// ************************************************************
module supply_supervisor_watchdog_tb;
  import supervisor_pkg::*;
  localparam int WL = 400;
  localparam int WS = 100;
  localparam int RL = 50;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [31:0] paddr, pwdata, prdata;
  logic        supply_below, supply_below_backup, watchdog_kick_in, watchdog_kick_float;
  logic        timebase_select, timebase_in, early_fail_sense, mem_select_in_n;
  logic        mem_select_out_n, watchdog_fault_n, supply_low_n, reset_n;
  logic        reset_hi_o, reset_hi_oe, early_fail_n, backup_active;
  logic        kick_run, glitch, ext_run, slow;
  int          fails, checked;

  supply_supervisor_watchdog #(.WD_LONG(WL), .WD_SHORT(WS), .RST_LEN(RL)) dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .irq, .supply_below, .supply_below_backup, .watchdog_kick_in,
    .watchdog_kick_float, .timebase_select, .timebase_in, .early_fail_sense,
    .mem_select_in_n, .mem_select_out_n, .watchdog_fault_n, .supply_low_n, .reset_n,
    .reset_hi_o, .reset_hi_oe, .early_fail_n, .backup_active);

  cpu_ram_model cpu (.pclk, .kick_run, .glitch, .ext_run, .slow,
    .kick(watchdog_kick_in), .timebase_in);

  // clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // compare and count
  task chk(input logic [31:0] s, input logic [31:0] e, input string m);
    checked++;
    if (s !== e) begin
      fails++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, s, e);
    end
  endtask : chk

  // one apb transfer, held until pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
           output logic [31:0] rd, output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {24'h0, a};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // cycles until reset output reaches a level
  task wait_rst(input logic lv, output int n);
    n = 0;
    while (reset_n !== lv && n < 10000) begin
      @(posedge pclk);
      n++;
    end
  endtask : wait_rst

  // cycles from last real kick change to fault, optional short pulse at gl
  task wait_fault(input int gl, output int n);
    logic lv;
    lv = cpu.level;
    n = 0;
    while (watchdog_fault_n !== 1'b0 && n < 5000) begin
      @(posedge pclk);
      n++;
      if (cpu.level !== lv) begin
        lv = cpu.level;
        n = 0;
      end
      glitch <= (n >= gl && n < gl + 4);
    end
  endtask : wait_fault

  // no fault and no reset for c cycles
  task quiet(input int c);
    int bad;
    bad = 0;
    repeat (c) begin
      @(posedge pclk);
      if (watchdog_fault_n !== 1'b1 || reset_n !== 1'b1) bad++;
    end
    chk(bad, 0, "fault or reset while quiet");
  endtask : quiet

  // power-on stretch, reset pair and memory gate
  task t_boot;
    int n, bad;
    n = 0;
    bad = 0;
    mem_select_in_n <= 1'b0;
    while (reset_n !== 1'b1 && n < 1000) begin
      @(posedge pclk);
      n++;
      if (reset_n === 1'b0 && (reset_hi_oe !== 1'b0 || mem_select_out_n !== 1'b1)) bad++;
    end
    chk(bad, 0, "high reset or select during reset");
    chk(n >= RL && n <= RL + 4, 1'b1, "stretch length");
    @(posedge pclk);
    chk(mem_select_out_n, 1'b0, "select passes");
    chk(reset_hi_oe, 1'b1, "high reset released");
    chk(reset_hi_o, 1'b0, "open drain level");
    mem_select_in_n <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(mem_select_out_n, 1'b1, "select follows high");
    $display("test boot done");
  endtask : t_boot

  // supply drop, backup flag, interrupts and registers
  task t_supply;
    int n;
    logic [31:0] d;
    logic e;
    apb(1'b1, IRQ_CLEAR_OFS, 32'hf, d, e);
    apb(1'b1, IRQ_ENABLE_OFS, 32'h2, d, e);
    supply_below <= 1'b1;
    watchdog_kick_float <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(supply_low_n, 1'b0, "low indicator");
    chk(reset_n, 1'b0, "reset on low supply");
    supply_below_backup <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(backup_active, 1'b1, "backup flag");
    chk(irq, 1'b1, "irq on supply fall");
    apb(1'b0, STATUS_OFS, 32'h0, d, e);
    chk(d & 32'hf, 32'he, "status fields");
    apb(1'b1, IRQ_ENABLE_OFS, 32'h0, d, e);
    @(posedge pclk);
    chk(irq, 1'b0, "irq masked");
    apb(1'b0, IRQ_STATUS_OFS, 32'h0, d, e);
    chk(d & 32'h2, 32'h2, "sticky bit kept");
    apb(1'b1, IRQ_CLEAR_OFS, 32'h2, d, e);
    apb(1'b0, IRQ_STATUS_OFS, 32'h0, d, e);
    chk(d & 32'h2, 32'h0, "sticky bit cleared");
    apb(1'b0, 8'h40, 32'h0, d, e);
    chk(e, 1'b1, "unmapped error");
    chk(d, 32'h0, "unmapped read");
    repeat (500) @(posedge pclk);
    chk(watchdog_fault_n, 1'b1, "watchdog frozen");
    watchdog_kick_float <= 1'b1;
    supply_below_backup <= 1'b0;
    supply_below <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(supply_low_n, 1'b1, "low indicator released");
    chk(reset_n, 1'b0, "reset still stretched");
    chk(backup_active, 1'b0, "backup flag off");
    wait_rst(1'b1, n);
    chk(n >= RL - 4 && n <= RL + 4, 1'b1, "recovery stretch");
    $display("test supply done");
  endtask : t_supply

  // comparators that must not touch reset
  task t_misc;
    early_fail_sense <= 1'b0;
    supply_below_backup <= 1'b1;
    mem_select_in_n <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(early_fail_n, 1'b0, "early fail low");
    chk(reset_n, 1'b1, "reset untouched");
    chk(backup_active, 1'b0, "backup needs low supply");
    chk(mem_select_out_n, 1'b0, "select unaffected");
    early_fail_sense <= 1'b1;
    supply_below_backup <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(early_fail_n, 1'b1, "early fail high");
    $display("test misc done");
  endtask : t_misc

  // select held at reset entry: time limit, then early release
  task t_mem;
    int n;
    supply_below <= 1'b1;
    n = 0;
    while (mem_select_out_n !== 1'b1 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    chk(n >= int'(CE_HOLD_CYC) - 5 && n <= int'(CE_HOLD_CYC) + 6, 1'b1, "hold limit");
    supply_below <= 1'b0;
    wait_rst(1'b1, n);
    @(posedge pclk);
    chk(mem_select_out_n, 1'b0, "select back");
    supply_below <= 1'b1;
    repeat (20) @(posedge pclk);
    chk(mem_select_out_n, 1'b0, "select held");
    mem_select_in_n <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(mem_select_out_n, 1'b1, "released by input");
    mem_select_in_n <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(mem_select_out_n, 1'b1, "blocked in reset");
    supply_below <= 1'b0;
    mem_select_in_n <= 1'b1;
    wait_rst(1'b1, n);
    $display("test mem done");
  endtask : t_mem

  // external timebase sets the stretch
  task t_ext;
    int n;
    logic [31:0] d;
    logic e;
    timebase_select <= 1'b0;
    ext_run <= 1'b1;
    supply_below <= 1'b1;
    repeat (3) @(posedge pclk);
    supply_below <= 1'b0;
    wait_rst(1'b1, n);
    chk(n >= 2 * int'(EXT_RST) - 16 && n <= 2 * int'(EXT_RST) + 14, 1'b1, "ext stretch");
    watchdog_kick_float <= 1'b0;
    wait_rst(1'b0, n);
    chk(n >= 2 * int'(EXT_WD_FIRST) - 16 && n <= 2 * int'(EXT_WD_FIRST) + 14, 1'b1,
        "ext first period");
    apb(1'b0, IRQ_STATUS_OFS, 32'h0, d, e);
    chk(d & 32'h1, 32'h1, "timeout event kept");
    watchdog_kick_float <= 1'b1;
    wait_rst(1'b1, n);
    timebase_select <= 1'b1;
    ext_run <= 1'b0;
    $display("test ext done");
  endtask : t_ext

  // watchdog periods, fault flag, pulses, filter, disable
  task t_wd;
    int n;
    logic [31:0] d;
    logic e;
    watchdog_kick_float <= 1'b0;
    supply_below <= 1'b1;
    repeat (3) @(posedge pclk);
    supply_below <= 1'b0;
    wait_rst(1'b1, n);
    wait_fault(10000, n);
    chk(n >= WL - 2 && n <= WL + 14, 1'b1, "first period");
    chk(reset_n, 1'b0, "watchdog reset");
    wait_rst(1'b1, n);
    chk(n >= RL - 2 && n <= RL + 4, 1'b1, "pulse length");
    wait_rst(1'b0, n);
    chk(n >= WL - 2 && n <= WL + 14, 1'b1, "pulse repeat");
    chk(watchdog_fault_n, 1'b0, "fault kept");
    kick_run <= 1'b1;
    repeat (40) @(posedge pclk);
    chk(watchdog_fault_n, 1'b1, "fault released by kick");
    wait_rst(1'b1, n);
    quiet(600);
    kick_run <= 1'b0;
    wait_fault(60, n);
    chk(n >= WS - 2 && n <= WS + 14, 1'b1, "fast period");
    wait_rst(1'b1, n);
    kick_run <= 1'b1;
    repeat (60) @(posedge pclk);
    kick_run <= 1'b0;
    slow <= 1'b1;
    wait_fault(10000, n);
    chk(n >= WL - 2 && n <= WL + 14, 1'b1, "slow period");
    wait_rst(1'b1, n);
    watchdog_kick_float <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(watchdog_fault_n, 1'b1, "fault high when floating");
    quiet(600);
    apb(1'b1, CTRL_OFS, 32'h0, d, e);
    watchdog_kick_float <= 1'b0;
    quiet(600);
    apb(1'b0, CTRL_OFS, 32'h0, d, e);
    chk(d, 32'h0, "watchdog enable cleared");
    apb(1'b1, CTRL_OFS, 32'h1, d, e);
    watchdog_kick_float <= 1'b1;
    $display("test watchdog done");
  endtask : t_wd

  // verdict
  task test_done;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done

  // main sequence
  initial begin
    fails = 0; checked = 0;
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 32'h0; pwdata = 32'h0; supply_below = 1'b0; supply_below_backup = 1'b0;
    watchdog_kick_float = 1'b1; timebase_select = 1'b1; early_fail_sense = 1'b1;
    mem_select_in_n = 1'b1; kick_run = 1'b0; glitch = 1'b0; ext_run = 1'b0; slow = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_boot;
    t_supply;
    t_misc;
    t_mem;
    t_ext;
    t_wd;
    test_done;
  end

  // hang guard, about three times the expected run
  initial begin
    #700_000;
    fails++;
    $display("unexpected at %0t: run timed out", $time);
    test_done;
  end
endmodule : supply_supervisor_watchdog_tb
`default_nettype wire
